// >>> hw/csi2_tx_link_engine.sv
// Link-side sequencer of one transmit port: buffer, calibration bursts, lanes.
// Assumes settings arrive already synchronised to clk_link.
`timescale 1ns/1ps
module csi2_tx_link_engine #(
  parameter int INIT_CAL_WORDS = csi2_tx_pkg::CAL_WORDS
) (
  input wire logic clk_link,
  input wire logic rst_link,
  input wire csi2_tx_pkg::link_cfg_t cfg,
  input wire logic single_req_tgl,
  output logic single_done_tgl,
  input wire logic s_valid,
  input wire logic [31:0] s_data,
  input wire logic s_frame_end,
  output logic s_ready,
  output logic hs_valid,
  output logic [31:0] hs_data,
  input wire logic hs_ready,
  output logic [3:0] lane_enable,
  output logic clk_lane_hs,
  output logic data_lp00,
  output logic clk_lp00,
  output logic deskew_active
);

  csi2_tx_pkg::link_state_t state;
  csi2_tx_pkg::word_t mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic [csi2_tx_pkg::CNT_W-1:0] cnt;
  logic req_seen;
  logic single_pend;
  logic periodic_pend;
  logic cal_single;
  logic first_pkt;
  logic gated;
  logic req_edge;
  logic push;
  logic pop;
  logic beat;
  logic cnt_last;
  logic start_cal;
  logic [7:0] pattern;

  // Port off or lanes held at LP00 stops all high-speed activity
  assign gated = !cfg.ctl.output_enable
    || cfg.ctl.forced_lp00_select == csi2_tx_pkg::LP00_DATA
    || cfg.ctl.forced_lp00_select == csi2_tx_pkg::LP00_ALL;
  assign req_edge = single_req_tgl != req_seen;
  assign s_ready = count != 2'h2;
  assign push = s_valid && s_ready;
  // Gating silences outputs in the cycle before the sequencer drops to idle
  assign pop = state == csi2_tx_pkg::LINK_HS && !gated && count != 2'h0 && hs_ready;
  assign deskew_active = !gated
    && (state == csi2_tx_pkg::LINK_INIT_CAL || state == csi2_tx_pkg::LINK_CAL);
  assign beat = deskew_active && hs_ready;
  assign cnt_last = cnt == '0;
  // Bursts wait for an idle link: nothing buffered to send
  assign start_cal = state == csi2_tx_pkg::LINK_HS && !gated && count == 2'h0
    && (single_pend || periodic_pend);
  assign pattern = cfg.deskew_pattern_invert ? csi2_tx_pkg::CAL_PATTERN_INV
    : csi2_tx_pkg::CAL_PATTERN;

  // Sequencer; disabling always wins over any burst in flight
  always_ff @(posedge clk_link)
  begin
    if (rst_link || gated)
    begin
      state <= csi2_tx_pkg::LINK_OFF;
      cnt <= '0;
    end
    else
    begin
      unique case (state)
        csi2_tx_pkg::LINK_OFF:
        begin
          if (cfg.ctl.init_deskew_enable)
          begin
            state <= csi2_tx_pkg::LINK_INIT_CAL;
            cnt <= csi2_tx_pkg::CNT_W'(INIT_CAL_WORDS - 1);
          end
          else
            state <= csi2_tx_pkg::LINK_HS;
        end
        csi2_tx_pkg::LINK_INIT_CAL, csi2_tx_pkg::LINK_CAL:
        begin
          if (beat && cnt_last)
            state <= csi2_tx_pkg::LINK_HS;
          else if (beat)
            cnt <= cnt - 1'b1;
        end
        csi2_tx_pkg::LINK_HS:
        begin
          if (start_cal)
          begin
            state <= csi2_tx_pkg::LINK_CAL;
            cnt <= csi2_tx_pkg::CNT_W'(csi2_tx_pkg::CAL_WORDS - 1);
          end
        end
      endcase
    end
  end

  // Single request bookkeeping; a new request beats the completion
  always_ff @(posedge clk_link)
  begin
    if (rst_link)
    begin
      req_seen <= 1'b0;
      single_pend <= 1'b0;
      cal_single <= 1'b0;
      single_done_tgl <= 1'b0;
    end
    else
    begin
      req_seen <= single_req_tgl;
      if (start_cal)
        cal_single <= single_pend;
      if (state == csi2_tx_pkg::LINK_CAL && beat && cnt_last && cal_single)
      begin
        single_done_tgl <= !single_done_tgl;
        cal_single <= 1'b0;
        single_pend <= req_edge;
      end
      else if (req_edge)
        single_pend <= 1'b1;
    end
  end

  // Frame End sent with periodic mode on asks for one burst
  always_ff @(posedge clk_link)
  begin
    if (rst_link)
      periodic_pend <= 1'b0;
    else if (pop && mem[rd_ptr].frame_end && cfg.periodic_deskew_enable)
      periodic_pend <= 1'b1;
    else if (start_cal)
      periodic_pend <= 1'b0;
  end

  // Two-entry buffer; a stalled receiver fills it and drops s_ready
  always_ff @(posedge clk_link)
  begin
    if (rst_link)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= '{frame_end: s_frame_end, data: s_data};
        wr_ptr <= !wr_ptr;
      end
      if (pop)
        rd_ptr <= !rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Continuous clock waits until a first word has gone out
  always_ff @(posedge clk_link)
  begin
    if (rst_link || state == csi2_tx_pkg::LINK_OFF)
      first_pkt <= 1'b0;
    else if (pop)
      first_pkt <= 1'b1;
  end

  // Lane drive; unused lanes carry zero
  always_comb
  begin
    lane_enable = 4'h0;
    hs_valid = 1'b0;
    hs_data = 32'h0;
    if (state != csi2_tx_pkg::LINK_OFF && !gated)
    begin
      lane_enable = csi2_tx_pkg::lane_mask(cfg.ctl.lane_count);
      hs_valid = deskew_active || count != 2'h0;
      for (int i = 0; i < csi2_tx_pkg::LANES; i++)
      begin
        if (lane_enable[i])
          hs_data[i*8 +: 8] = deskew_active ? pattern : mem[rd_ptr].data[i*8 +: 8];
      end
    end
  end

  assign clk_lane_hs = state != csi2_tx_pkg::LINK_OFF && !gated && (hs_valid
    || (cfg.ctl.continuous_clock_enable && first_pkt));
  assign data_lp00 = cfg.ctl.output_enable && cfg.ctl.forced_lp00_select[0];
  assign clk_lp00 = cfg.ctl.output_enable
    && cfg.ctl.forced_lp00_select == csi2_tx_pkg::LP00_ALL;

endmodule

// >>> hw/csi2_tx_pkg.sv
// Shared constants and types for the two-port CSI-2 transmit control block.
// Assumes an 8-bit register port and a 32-bit, four-lane word per link cycle.
package csi2_tx_pkg;

  // Register offsets
  localparam logic [7:0] OFS_PORT_SEL = 8'h32;
  localparam logic [7:0] OFS_CTL = 8'h33;
  localparam logic [7:0] OFS_CTL2 = 8'h34;
  localparam logic [7:0] OFS_STS = 8'h35;

  // Field positions in the port select and status registers
  localparam int READ_PORT_BIT = 4;
  localparam int WRITE_PORT0_BIT = 0;
  localparam int WRITE_PORT1_BIT = 1;
  localparam int PASS_BIT = 0;

  // Values after reset
  localparam logic [7:0] PORT_SEL_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL2_RESET = 8'h00;

  // Writable bits; reserved bits stay zero
  localparam logic [7:0] PORT_SEL_WMASK = 8'h13;
  localparam logic [7:0] CTL_WMASK = 8'h7F;
  localparam logic [7:0] CTL2_WMASK = 8'h0D;

  // Line state codes
  localparam logic [1:0] LP00_NORMAL = 2'h0;
  localparam logic [1:0] LP00_DATA = 2'h1;
  localparam logic [1:0] LP00_ALL = 2'h3;

  // Skew calibration: 2^10 bits per lane, eight bits per lane per word
  localparam int LANES = 4;
  localparam int LANE_BITS = 8;
  localparam int CAL_BITS = 1024;
  localparam int CAL_WORDS = CAL_BITS / LANE_BITS;
  localparam int CNT_W = 16;
  localparam logic [7:0] CAL_PATTERN = 8'h55;
  localparam logic [7:0] CAL_PATTERN_INV = 8'hAA;

  // Layout of the control register, bit 7 first
  typedef struct packed {
    logic rsv;
    logic init_deskew_enable;
    logic [1:0] lane_count;
    logic [1:0] forced_lp00_select;
    logic continuous_clock_enable;
    logic output_enable;
  } ctl_t;

  // Layout of the calibration control register, bit 7 first
  typedef struct packed {
    logic [3:0] rsv;
    logic pass_all_mode;
    logic deskew_pattern_invert;
    logic single_deskew;
    logic periodic_deskew_enable;
  } ctl2_t;

  // Settings handed to the link domain
  typedef struct packed {
    ctl_t ctl;
    logic deskew_pattern_invert;
    logic periodic_deskew_enable;
  } link_cfg_t;

  // One buffered stream word
  typedef struct packed {
    logic frame_end;
    logic [LANES*LANE_BITS-1:0] data;
  } word_t;

  typedef enum logic [1:0] {
    LINK_OFF = 2'b00,
    LINK_INIT_CAL = 2'b01,
    LINK_HS = 2'b10,
    LINK_CAL = 2'b11
  } link_state_t;

  // Active data lanes for a lane count code
  function automatic logic [LANES-1:0] lane_mask(input logic [1:0] code);
    logic [LANES-1:0] m;
    m = 4'hF;
    unique case (code)
      2'h0: m = 4'hF;
      2'h1: m = 4'h7;
      2'h2: m = 4'h3;
      2'h3: m = 4'h1;
    endcase
    return m;
  endfunction

endpackage

// >>> hw/csi2_tx_port_control.sv
// Paged control registers and link sequencing for two CSI-2 transmit ports.
// Assumes the serial-bus front end presents byte reads and writes as strobes
// on CLK_SYS, and that stream and PHY sides run on CLK_LINK.
// How it works
// - Read page bit picks port readback
// - Write enables pick ports, both allowed
// - Initial deskew before any high-speed data
// - Lane count code picks active lanes
// - Forced LP00 on data or all lanes
// - Continuous clock after first packet sent
// - Output enable gates all link outputs; buffer still takes two words, pass still updates
// - Pass needs one or all enabled ports
// - Calibration pattern alternates, invertible start bit
// - Single request sends one burst when idle
// - Single request bit clears after burst
// - Periodic burst after every Frame End
// - Status shows selected read port number
`timescale 1ns/1ps
module csi2_tx_port_control #(
  parameter int INIT_CAL_WORDS = csi2_tx_pkg::CAL_WORDS
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CLK_LINK,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic [3:0] RX_PORT_ENABLED,
  input wire logic [3:0] RX_VIDEO_VALID,
  output logic [1:0] TX_PASS,
  input wire logic [1:0] S_VALID,
  input wire logic [1:0][31:0] S_DATA,
  input wire logic [1:0] S_FRAME_END,
  output logic [1:0] S_READY,
  output logic [1:0] HS_VALID,
  output logic [1:0][31:0] HS_DATA,
  input wire logic [1:0] HS_READY,
  output logic [1:0][3:0] LANE_ENABLE,
  output logic [1:0] CLK_LANE_HS,
  output logic [1:0] DATA_LP00,
  output logic [1:0] CLK_LP00,
  output logic [1:0] DESKEW_ACTIVE
);

  // Register hit on a given offset, shared by write and read decode
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  logic read_port;
  logic [1:0] write_en;
  csi2_tx_pkg::ctl_t [1:0] ctl;
  csi2_tx_pkg::ctl2_t [1:0] ctl2;
  logic [1:0] single_pend;
  logic [1:0] req_tgl;
  logic [1:0] done_meta;
  logic [1:0] done_sync;
  logic [1:0] done_seen;
  logic [1:0] done_tgl;
  logic [1:0] done_evt;
  logic [1:0] pass;
  logic [7:0] next_rdata;
  logic wr_sel;
  logic wr_ctl;
  logic wr_ctl2;
  logic rst_link_meta;
  logic rst_link;
  csi2_tx_pkg::link_cfg_t [1:0] cfg_sys;
  csi2_tx_pkg::link_cfg_t [1:0] cfg_meta;
  csi2_tx_pkg::link_cfg_t [1:0] cfg_sync;
  csi2_tx_pkg::link_cfg_t [1:0] cfg_prev;
  csi2_tx_pkg::link_cfg_t [1:0] cfg_link;
  logic [1:0] req_meta;
  logic [1:0] req_sync;

  assign wr_sel = REG_WR && reg_hit(REG_ADDR, csi2_tx_pkg::OFS_PORT_SEL);
  assign wr_ctl = REG_WR && reg_hit(REG_ADDR, csi2_tx_pkg::OFS_CTL);
  assign wr_ctl2 = REG_WR && reg_hit(REG_ADDR, csi2_tx_pkg::OFS_CTL2);

  // Page select: reserved bits are never stored
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      read_port <= csi2_tx_pkg::PORT_SEL_RESET[csi2_tx_pkg::READ_PORT_BIT];
      write_en <= csi2_tx_pkg::PORT_SEL_RESET[1:0];
    end
    else if (wr_sel)
    begin
      read_port <= REG_WDATA[csi2_tx_pkg::READ_PORT_BIT];
      write_en[0] <= REG_WDATA[csi2_tx_pkg::WRITE_PORT0_BIT];
      write_en[1] <= REG_WDATA[csi2_tx_pkg::WRITE_PORT1_BIT];
    end
  end

  // Per-port register copies and their crossings into the link domain
  for (genvar p = 0; p < 2; p++)
  begin : g_port

    // Control register copy, written only when this port is enabled
    always_ff @(posedge CLK_SYS)
    begin
      if (RST)
        ctl[p] <= csi2_tx_pkg::ctl_t'(csi2_tx_pkg::CTL_RESET);
      else if (wr_ctl && write_en[p])
        ctl[p] <= csi2_tx_pkg::ctl_t'(REG_WDATA & csi2_tx_pkg::CTL_WMASK);
    end

    // Calibration register copy, plain read/write fields only
    always_ff @(posedge CLK_SYS)
    begin
      if (RST)
        ctl2[p] <= csi2_tx_pkg::ctl2_t'(csi2_tx_pkg::CTL2_RESET);
      else if (wr_ctl2 && write_en[p])
        ctl2[p] <= csi2_tx_pkg::ctl2_t'(REG_WDATA & csi2_tx_pkg::CTL2_WMASK);
    end

    // Single request: writing 1 raises it, the finished burst drops it.
    // A write of 1 in the same cycle as the completion keeps it raised.
    always_ff @(posedge CLK_SYS)
    begin
      if (RST)
      begin
        single_pend[p] <= 1'b0;
        req_tgl[p] <= 1'b0;
      end
      else if (wr_ctl2 && write_en[p] && REG_WDATA[1] && (!single_pend[p] || done_evt[p]))
      begin
        single_pend[p] <= 1'b1;
        req_tgl[p] <= !req_tgl[p];
      end
      else if (done_evt[p])
        single_pend[p] <= 1'b0;
    end

    // Completion toggle back from the link domain
    always_ff @(posedge CLK_SYS)
    begin
      if (RST)
      begin
        done_meta[p] <= 1'b0;
        done_sync[p] <= 1'b0;
        done_seen[p] <= 1'b0;
      end
      else
      begin
        done_meta[p] <= done_tgl[p];
        done_sync[p] <= done_meta[p];
        done_seen[p] <= done_sync[p];
      end
    end
    assign done_evt[p] = done_sync[p] != done_seen[p];

    // Pass: any enabled port valid, or every enabled port valid
    always_ff @(posedge CLK_SYS)
    begin
      if (RST)
        pass[p] <= 1'b0;
      else if (ctl2[p].pass_all_mode)
        pass[p] <= RX_PORT_ENABLED != 4'h0
          && &(RX_VIDEO_VALID | ~RX_PORT_ENABLED);
      else
        pass[p] <= |(RX_VIDEO_VALID & RX_PORT_ENABLED);
    end

    assign cfg_sys[p] = '{
      ctl: ctl[p],
      deskew_pattern_invert: ctl2[p].deskew_pattern_invert,
      periodic_deskew_enable: ctl2[p].periodic_deskew_enable
    };

    // Settings are levels: synchronised, then used only once two samples
    // agree, so a write caught mid-sample never lands half applied.
    // Cost: two more link cycles before a new setting takes hold.
    always_ff @(posedge CLK_LINK)
    begin
      if (rst_link)
      begin
        cfg_meta[p] <= '0;
        cfg_sync[p] <= '0;
        cfg_prev[p] <= '0;
        cfg_link[p] <= '0;
      end
      else
      begin
        cfg_meta[p] <= cfg_sys[p];
        cfg_sync[p] <= cfg_meta[p];
        cfg_prev[p] <= cfg_sync[p];
        if (cfg_sync[p] == cfg_prev[p])
          cfg_link[p] <= cfg_sync[p];
      end
    end

    // Single request toggle into the link domain
    always_ff @(posedge CLK_LINK)
    begin
      if (rst_link)
      begin
        req_meta[p] <= 1'b0;
        req_sync[p] <= 1'b0;
      end
      else
      begin
        req_meta[p] <= req_tgl[p];
        req_sync[p] <= req_meta[p];
      end
    end

    csi2_tx_link_engine #(
      .INIT_CAL_WORDS(INIT_CAL_WORDS)
    ) u_engine (
      .clk_link(CLK_LINK),
      .rst_link(rst_link),
      .cfg(cfg_link[p]),
      .single_req_tgl(req_sync[p]),
      .single_done_tgl(done_tgl[p]),
      .s_valid(S_VALID[p]),
      .s_data(S_DATA[p]),
      .s_frame_end(S_FRAME_END[p]),
      .s_ready(S_READY[p]),
      .hs_valid(HS_VALID[p]),
      .hs_data(HS_DATA[p]),
      .hs_ready(HS_READY[p]),
      .lane_enable(LANE_ENABLE[p]),
      .clk_lane_hs(CLK_LANE_HS[p]),
      .data_lp00(DATA_LP00[p]),
      .clk_lp00(CLK_LP00[p]),
      .deskew_active(DESKEW_ACTIVE[p])
    );
  end

  // Reset carried into the link domain; released two link edges late
  always_ff @(posedge CLK_LINK)
  begin
    rst_link_meta <= RST;
    rst_link <= rst_link_meta;
  end

  // Readback always from the read page, whatever the write enables say
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_hit(REG_ADDR, csi2_tx_pkg::OFS_PORT_SEL))
    begin
      next_rdata[csi2_tx_pkg::READ_PORT_BIT] = read_port;
      next_rdata[1:0] = write_en;
    end
    else if (reg_hit(REG_ADDR, csi2_tx_pkg::OFS_CTL))
      next_rdata = ctl[read_port];
    else if (reg_hit(REG_ADDR, csi2_tx_pkg::OFS_CTL2))
    begin
      next_rdata = ctl2[read_port];
      next_rdata[1] = single_pend[read_port];
    end
    else if (reg_hit(REG_ADDR, csi2_tx_pkg::OFS_STS))
    begin
      next_rdata[csi2_tx_pkg::READ_PORT_BIT] = read_port;
      next_rdata[csi2_tx_pkg::PASS_BIT] = pass[read_port];
    end
  end

  // Read answer one cycle after the strobe; unmapped offsets give zero
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= next_rdata;
    end
  end

  assign TX_PASS = pass;

endmodule

// >>> tb/csi2_rx_model.sv
// Downstream receiver of one transmit port: takes words, counts calibration words.
// Assumes the link clock and reset of the port that it faces.
`timescale 1ns/1ps
module csi2_rx_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic hs_valid,
  input wire logic [31:0] hs_data,
  input wire logic deskew,
  input wire logic slow,
  output logic hs_ready = 1'b0
);
  logic [31:0] words[$];
  int cal_count = 0;
  logic [31:0] last_cal = 32'h0;
  // Ready moves off the sampling edge; slow mode stalls one beat in three
  always @(negedge clk)
    hs_ready <= !rst && (!slow || $urandom_range(2) != 0);
  // Accepted beats are sorted into calibration and data
  always @(posedge clk)
  begin
    if (hs_valid && hs_ready && deskew)
    begin
      cal_count <= cal_count + 1;
      last_cal <= hs_data;
    end
    else if (hs_valid && hs_ready)
      words.push_back(hs_data);
  end
endmodule

// >>> tb/csi2_tx_port_control_props.sv
// Port-level assertions for the two-port transmit control block.
// Assumes it is bound to every csi2_tx_port_control and sees only its ports.
`timescale 1ns/1ps
module csi2_tx_port_control_props (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CLK_LINK,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic [3:0] RX_PORT_ENABLED,
  input wire logic [3:0] RX_VIDEO_VALID,
  input wire logic [1:0] TX_PASS,
  input wire logic [1:0] HS_VALID,
  input wire logic [1:0][31:0] HS_DATA,
  input wire logic [1:0][3:0] LANE_ENABLE,
  input wire logic [1:0] DATA_LP00,
  input wire logic [1:0] CLK_LP00,
  input wire logic [1:0] DESKEW_ACTIVE
);
  logic page;
  logic [31:0] off0;
  // Read page mirrored from select writes, so status can be judged
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      page <= 1'b0;
    else if (REG_WR && REG_ADDR == csi2_tx_pkg::OFS_PORT_SEL)
      page <= REG_WDATA[csi2_tx_pkg::READ_PORT_BIT];
  end
  // Byte lanes of port 0 that are switched off
  assign off0 = ~{{8{LANE_ENABLE[0][3]}}, {8{LANE_ENABLE[0][2]}},
    {8{LANE_ENABLE[0][1]}}, {8{LANE_ENABLE[0][0]}}};
  // A read request and its answer one cycle later
  sequence rd_of(logic [7:0] a);
    REG_RD && REG_ADDR == a ##1 REG_RVALID;
  endsequence
  property rd_bits(logic [7:0] a, logic [7:0] m);
    @(posedge CLK_SYS) disable iff (RST) rd_of(a) |-> (REG_RDATA & m) == 8'h00;
  endproperty
  a_rvalid_follows: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_RD |=> REG_RVALID) else $error("read answer missing");
  a_rvalid_spurious: assert property (@(posedge CLK_SYS) disable iff (RST)
    !REG_RD |=> !REG_RVALID) else $error("read answer without request");
  a_rdata_holds: assert property (@(posedge CLK_SYS) disable iff (RST)
    !REG_RD |=> $stable(REG_RDATA)) else $error("read data moved without read");
  a_ctl_rsv_zero: assert property (rd_bits(csi2_tx_pkg::OFS_CTL, 8'h80))
    else $error("control reserved bit set");
  a_ctl2_rsv_zero: assert property (rd_bits(csi2_tx_pkg::OFS_CTL2, 8'hF0))
    else $error("calibration reserved bits set");
  a_sel_rsv_zero: assert property (rd_bits(csi2_tx_pkg::OFS_PORT_SEL, 8'hEC))
    else $error("select reserved bits set");
  a_sts_read_page: assert property (@(posedge CLK_SYS) disable iff (RST)
    rd_of(csi2_tx_pkg::OFS_STS) |-> REG_RDATA[4] == page && (REG_RDATA & 8'hEE) == 8'h00)
    else $error("status port number wrong");
  a_pass_none: assert property (@(posedge CLK_SYS) disable iff (RST)
    !$past(RST) && ($past(RX_PORT_ENABLED) & $past(RX_VIDEO_VALID)) == 4'h0
    |-> TX_PASS == 2'b00) else $error("pass without valid video");
  a_pass_full: assert property (@(posedge CLK_SYS) disable iff (RST)
    !$past(RST) && $past(RX_PORT_ENABLED) != 4'h0
    && ($past(RX_VIDEO_VALID) & $past(RX_PORT_ENABLED)) == $past(RX_PORT_ENABLED)
    |-> TX_PASS == 2'b11) else $error("pass missing with all valid");
  a_lp00_no_lanes: assert property (@(posedge CLK_LINK) disable iff (RST)
    DATA_LP00[0] |-> LANE_ENABLE[0] == 4'h0) else $error("lanes active in LP00");
  a_clk_lp00_data: assert property (@(posedge CLK_LINK) disable iff (RST)
    (CLK_LP00 & ~DATA_LP00) == 2'b00) else $error("clock LP00 without data LP00");
  a_lane_shape: assert property (@(posedge CLK_LINK) disable iff (RST)
    LANE_ENABLE[0] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}) else $error("bad lane set");
  a_off_lanes_zero: assert property (@(posedge CLK_LINK) disable iff (RST)
    HS_VALID[0] |-> (HS_DATA[0] & off0) == 32'h0) else $error("idle lane carries data");
  a_cal_pattern: assert property (@(posedge CLK_LINK) disable iff (RST)
    DESKEW_ACTIVE[0] && HS_VALID[0] |-> HS_DATA[0][7:0] inside {8'h55, 8'hAA})
    else $error("calibration byte not alternating");
endmodule
bind csi2_tx_port_control csi2_tx_port_control_props props (.*);

// >>> tb/csi2_tx_port_control_tb.sv
// Self-checking bench: paged registers, pass logic, link bursts and buffering.
// Assumes one receiver model per port on the link side.
`timescale 1ns/1ps
module csi2_tx_port_control_tb;
  localparam int ICW = 4;
  logic CLK_SYS = 1'b0;
  logic CLK_LINK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic REG_RVALID;
  logic [3:0] RX_PORT_ENABLED = 4'h0;
  logic [3:0] RX_VIDEO_VALID = 4'h0;
  logic [1:0] TX_PASS;
  logic [1:0] S_VALID = 2'b00;
  logic [1:0][31:0] S_DATA = 64'h0;
  logic [1:0] S_FRAME_END = 2'b00;
  logic [1:0] S_READY, HS_VALID, HS_READY, CLK_LANE_HS, DATA_LP00, CLK_LP00, DESKEW_ACTIVE;
  logic [1:0][31:0] HS_DATA;
  logic [1:0][3:0] LANE_ENABLE;
  logic [1:0] slow = 2'b01;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] r, c0, c1, c2;
  logic [1:0] code;
  logic [31:0] w[3];

  // Clocks at unrelated phases
  always #12.5 CLK_SYS = ~CLK_SYS;
  always #40 CLK_LINK = ~CLK_LINK;

  csi2_tx_port_control #(.INIT_CAL_WORDS(ICW)) dut (.*);
  csi2_rx_model rx[1:0] (.clk(CLK_LINK), .rst(RST), .hs_valid(HS_VALID), .hs_data(HS_DATA),
    .deskew(DESKEW_ACTIVE), .slow(slow), .hs_ready(HS_READY));

  function automatic logic [3:0] lanes(input logic [1:0] c);
    return (c == 2'h0) ? 4'hF : (c == 2'h1) ? 4'h7 : (c == 2'h2) ? 4'h3 : 4'h1;
  endfunction
  function automatic logic [31:0] wmask(input logic [1:0] c);
    logic [3:0] l;
    l = lanes(c);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  function automatic logic pexp(input logic all, input logic [3:0] e, input logic [3:0] v);
    return all ? (e != 4'h0 && (e & v) == e) : ((e & v) != 4'h0);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK_SYS);
    REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK_SYS);
    REG_RD = 1'b0;
    check(REG_RVALID, 1'b1);
    check(REG_RDATA, exp);
  endtask
  task automatic wl(input int n);
    repeat (n) @(negedge CLK_LINK);
  endtask
  // Word held until the buffer takes it at a rising edge
  task automatic send(input int p, input logic [31:0] d, input logic fe);
    @(negedge CLK_LINK);
    S_VALID[p] = 1'b1;
    S_DATA[p] = d;
    S_FRAME_END[p] = fe;
    for (int i = 0; i < 300 && S_READY[p] !== 1'b1; i++)
      @(negedge CLK_LINK);
    check(S_READY[p], 1'b1);
    @(negedge CLK_LINK);
    S_VALID[p] = 1'b0;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog sized well above the expected run
  initial
  begin
    #400000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'hF2A5647D));
    repeat (12) @(negedge CLK_SYS);
    RST = 1'b0;
    for (int a = 8'h32; a <= 8'h35; a++)
      rd(a[7:0], 8'h00);
    c0 = $urandom & 8'hFE; // Port 0 stays off until its own burst test
    c1 = $urandom;
    c2 = $urandom & 8'hFD;
    // Shared write, then single-port writes, then a write with no port enabled
    wr(8'h32, 8'hFF);
    rd(8'h32, 8'h13);
    wr(8'h33, c0);
    wr(8'h32, 8'h02);
    wr(8'h33, c1);
    wr(8'h32, 8'h01);
    wr(8'h34, c2);
    wr(8'h32, 8'h00);
    wr(8'h33, ~c0);
    rd(8'h33, c0 & 8'h7F);
    rd(8'h34, c2 & 8'h0D);
    rd(8'h35, 8'h00);
    wr(8'h32, 8'h13);
    rd(8'h33, c1 & 8'h7F);
    rd(8'h34, 8'h00);
    rd(8'h35, 8'h10);
    wr(8'h32, 8'h11);
    rd(8'h40, 8'h00);
    wr(8'h32, 8'h01);
    // Pass modes: port 0 needs all, port 1 any
    wr(8'h34, 8'h08);
    wr(8'h32, 8'h02);
    wr(8'h34, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      @(negedge CLK_SYS);
      RX_PORT_ENABLED = (i == 0) ? 4'h0 : $urandom;
      RX_VIDEO_VALID = (i < 2) ? 4'hF : $urandom;
      repeat (2) @(negedge CLK_SYS);
      check(TX_PASS, {pexp(1'b0, RX_PORT_ENABLED, RX_VIDEO_VALID),
        pexp(1'b1, RX_PORT_ENABLED, RX_VIDEO_VALID)});
    end
    // Ports off: port 1 takes two words, drops s_ready, sends nothing
    wr(8'h32, 8'h03);
    wr(8'h33, 8'h00);
    wr(8'h34, 8'h00);
    wl(10);
    @(negedge CLK_LINK);
    S_DATA[1] = $urandom;
    S_VALID[1] = 1'b1;
    wl(6);
    check(S_READY[1], 1'b0);
    check(HS_VALID[1], 1'b0);
    S_VALID[1] = 1'b0;
    // Port 0: initial inverted burst, continuous clock, periodic burst
    code = $urandom;
    wr(8'h32, 8'h01);
    wr(8'h34, 8'h05);
    wr(8'h33, 8'h43 | {2'b00, code, 4'h0});
    wl(40);
    check(rx[0].cal_count, ICW);
    check(rx[0].words.size(), 0);
    check(CLK_LANE_HS[0], 1'b0);
    check(rx[0].last_cal, 32'hAAAAAAAA & wmask(code));
    foreach (w[i])
    begin
      w[i] = $urandom;
      send(0, w[i], i == 2);
    end
    wl(400);
    foreach (w[i])
      check(rx[0].words[i], w[i] & wmask(code));
    check(rx[0].cal_count, ICW + 128);
    check(CLK_LANE_HS[0], 1'b1);
    check(LANE_ENABLE[0], lanes(code));
    // One requested burst, plain pattern, bit clears afterwards
    wr(8'h34, 8'h02);
    rd(8'h34, 8'h02);
    wl(400);
    rd(8'h34, 8'h00);
    check(rx[0].cal_count, ICW + 256);
    check(rx[0].last_cal, 32'h55555555 & wmask(code));
    // Each lane count code paired with the line state code of the same value
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h33, 8'h01 | (i[7:0] << 4) | (i[7:0] << 2));
      wl(10);
      check(LANE_ENABLE[0], i[0] ? 4'h0 : lanes(i[1:0]));
      check(DATA_LP00[0], i[0]);
      check(CLK_LP00[0], i == 3);
    end
    // Port 1 drains the two held words once enabled
    wr(8'h32, 8'h02);
    wr(8'h33, 8'h01);
    wl(30);
    check(rx[1].words.size(), 2);
    check(rx[1].words[1], S_DATA[1]);
    wr(8'h32, 8'h03);
    wr(8'h33, 8'h00);
    wl(10);
    check(LANE_ENABLE, 8'h00);
    check(HS_VALID, 2'b00);
    print_verdict();
  end
endmodule
